// File: logic/psd_pkg.sv
// Constants, field layout and carrier types of the synthesizer digital core
// Overview of operation
// - Reference divider is a 10-bit counter, ratio 2 to 1023; below 2 prohibited.
// - Reference divider counts edges of the reference oscillator input, up to 40 MHz.
// - Feedback divider: 5-bit swallow and 10-bit main counter, ratio 992 to 32767.
// - A 32/33 dual-modulus prescaler divides the RF input and clocks both counters.
// - Phase detector compares reference and feedback divider outputs, up to 10 MHz.
// - Polarity select swaps pump-up and pump-down commands.
// - Detector sees pump activity and holds minimum pulses, so no dead zone.
// - Pump drives high for up, low for down, otherwise floats.
// - Test bit routes a divider output to the pump; polarity picks which.
// - In lock the divided RF equals the comparison frequency.
// - Serial data is sampled on each rising serial clock into an 18-bit register.
// - Rising load strobe copies the shift register into the selected latch.
// - Select 1 loads reference and control latch, select 0 the feedback latch.
// - Chip enable low powers down and floats the pump regardless of the bit.
// - Power-down bit stops both dividers and floats the RF and reference inputs.
// - Any power-down forces pump output and detector into the floating state.
// - Entering power-down resets both dividers to their starting counts.
// - Leaving power-down restarts both dividers together, within one prescaler cycle.
// - Serial loading keeps working in every power-down mode.
package psd_pkg;
	// Serial word layout
	localparam int SR_W = 18;
	localparam int ADDR_BIT = 0;
	localparam logic SEL_REF = 1'b1;
	// Reference and control latch fields (shift register positions)
	localparam int R_RATIO_LSB = 1;
	localparam int R_LATCH_LSB = 1;
	localparam int R_LATCH_MSB = 14;
	localparam int R_W = 10;
	// Feedback latch fields (shift register positions)
	localparam int N_LATCH_LSB = 1;
	localparam int N_LATCH_MSB = 17;
	localparam int A_W = 5;
	localparam int B_W = 10;
	// Prescaler moduli
	localparam int PRE_W = 6;
	localparam logic [PRE_W-1:0] PRE_LOW = 6'h20;
	localparam logic [PRE_W-1:0] PRE_HIGH = 6'h21;
	// Legal reference ratio range
	localparam logic [R_W-1:0] R_RATIO_MIN = 10'h002;
	localparam logic [R_W-1:0] R_RATIO_MAX = 10'h3ff;
	// Input rate limits in MHz, for the verification side
	localparam int OSC_MAX_MHZ = 40;
	localparam int PFD_MAX_MHZ = 10;
	// Minimum detector pulse, the dead-zone guard
	localparam int CLK_PERIOD_PS = 4000;
	localparam int PFD_MIN_PULSE_NS = 8;
	localparam int PFD_MIN_PULSE_CYC_RAW =
		(PFD_MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PFD_MIN_PULSE_CYC = (PFD_MIN_PULSE_CYC_RAW < 1) ? 1 : PFD_MIN_PULSE_CYC_RAW;
	localparam int ABL_W = $clog2(PFD_MIN_PULSE_CYC + 1);
	localparam logic [ABL_W-1:0] ABL_LAST = ABL_W'(PFD_MIN_PULSE_CYC - 1);

	// Reference and control latch, packed as it sits in the shift register
	typedef struct packed {
		logic test;
		logic reserved;
		logic polarity;
		logic pump_output_float;
		logic [R_W-1:0] ratio;
	} psd_r_latch_type;

	// Feedback latch, packed as it sits in the shift register
	typedef struct packed {
		logic [B_W-1:0] main_count;
		logic [A_W-1:0] swallow_count;
		logic power_down_bit;
		logic ctl_spare;
	} psd_n_latch_type;

	// Pump pin and command view
	typedef struct packed {
		logic level;
		logic oe;
		logic up;
		logic down;
	} psd_pump_type;

	// Reset values of the latches
	localparam psd_r_latch_type R_LATCH_RST = '{test: 1'b0, reserved: 1'b0, polarity: 1'b1,
		pump_output_float: 1'b1, ratio: R_RATIO_MIN};
	localparam psd_n_latch_type N_LATCH_RST = '{main_count: 10'h020, swallow_count: 5'h00,
		power_down_bit: 1'b1, ctl_spare: 1'b0};
endpackage : psd_pkg

// File: logic/psd_div.sv
// Programmable divider: counts ticks, pulses once per ratio ticks
`timescale 1ns/1ps
`default_nettype none
module psd_div #(
	parameter int W = 10
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Count control
	input wire logic tick_in,
	input wire logic clear_in,
	input wire logic [W-1:0] ratio_in,
	// Terminal pulse
	output logic wrap_out
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic wrap;
	} psd_div_state_type;

	psd_div_state_type state;
	psd_div_state_type next_state;

	// Count up and compare, so a new ratio takes effect within the running cycle
	always_comb begin
		next_state = state;
		next_state.wrap = 1'b0;
		if (clear_in) begin
			next_state.cnt = '0;
		end else if (tick_in) begin
			if (state.cnt >= ratio_in - W'(1)) begin
				next_state.cnt = '0;
				next_state.wrap = 1'b1;
			end else begin
				next_state.cnt = state.cnt + W'(1);
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign wrap_out = state.wrap;

	property p_wrap_cause;
		@(posedge clk_in) disable iff (!rst_n_in)
		wrap_out |-> $past(tick_in) && !$past(clear_in) && state.cnt == '0;
	endproperty
	a_wrap_cause: assert property (p_wrap_cause)
		else $error("divider pulsed without a terminal tick");
endmodule : psd_div
`default_nettype wire

// File: logic/psd_core.sv
// Synthesizer digital core: serial latches, dividers, detector and pump
`timescale 1ns/1ps
`default_nettype none
module psd_core
	import psd_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Divider sources
	input wire logic reference_osc_input_in,
	input wire logic rf_input_in,
	// Power control
	input wire logic chip_enable_in,
	// Serial programming port
	input wire logic ser_clk_in,
	input wire logic ser_data_in,
	input wire logic latch_load_strobe_in,
	// Pump pin and commands
	output logic pump_output_out,
	output logic pump_output_oe_out,
	output logic pump_up_out,
	output logic pump_down_out,
	// Divider outputs
	output logic ref_div_out,
	output logic fb_div_out,
	// Power state
	output logic powered_down_out,
	output logic rf_input_float_out,
	output logic osc_input_float_out
);
	typedef struct packed {
		logic [SR_W-1:0] shift;
		logic ser_clk_q;
		logic strobe_q;
		logic osc_q;
		logic rf_q;
		psd_r_latch_type r_latch;
		psd_n_latch_type n_latch;
		logic [A_W-1:0] a_left;
		logic ref_flag;
		logic fb_flag;
		logic [ABL_W-1:0] abl_cnt;
		psd_pump_type pump;
		logic ref_div;
		logic fb_div;
		logic powered_down;
		logic rf_float;
		logic osc_float;
	} psd_core_state_type;

	psd_core_state_type state;
	psd_core_state_type next_state;

	logic pd_now;
	logic osc_rise;
	logic rf_rise;
	logic ref_wrap;
	logic pre_wrap;
	logic fb_wrap;
	logic [PRE_W-1:0] pre_ratio;

	// Power-down from the pin or the programmed bit
	assign pd_now = !chip_enable_in || state.n_latch.power_down_bit;
	assign osc_rise = reference_osc_input_in && !state.osc_q;
	assign rf_rise = rf_input_in && !state.rf_q;
	// Modulus 33 while swallow count remains, then 32
	assign pre_ratio = (state.a_left != '0) ? PRE_HIGH : PRE_LOW;

	// Reference divider, ticked by the reference oscillator
	psd_div #(.W(R_W)) u_ref_div (
		.clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.tick_in(osc_rise && !pd_now),
		.clear_in(pd_now),
		.ratio_in(state.r_latch.ratio),
		.wrap_out(ref_wrap)
	);

	// Dual-modulus prescaler on the RF input
	psd_div #(.W(PRE_W)) u_prescaler (
		.clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.tick_in(rf_rise && !pd_now),
		.clear_in(pd_now),
		.ratio_in(pre_ratio),
		.wrap_out(pre_wrap)
	);

	// Main counter, ticked by the prescaler
	psd_div #(.W(B_W)) u_main_div (
		.clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.tick_in(pre_wrap && !pd_now),
		.clear_in(pd_now),
		.ratio_in(state.n_latch.main_count),
		.wrap_out(fb_wrap)
	);

	// Next state of the whole core
	always_comb begin
		next_state = state;
		next_state.ser_clk_q = ser_clk_in;
		next_state.strobe_q = latch_load_strobe_in;
		next_state.osc_q = reference_osc_input_in;
		next_state.rf_q = rf_input_in;

		// Serial port ignores power-down, so software can always wake the part from bit power-down
		if (ser_clk_in && !state.ser_clk_q) begin
			next_state.shift = {state.shift[SR_W-2:0], ser_data_in};
		end
		if (latch_load_strobe_in && !state.strobe_q) begin
			if (state.shift[ADDR_BIT] == SEL_REF) begin
				next_state.r_latch = state.shift[R_LATCH_MSB:R_LATCH_LSB];
			end else begin
				next_state.n_latch = state.shift[N_LATCH_MSB:N_LATCH_LSB];
			end
		end

		// Swallow counter: restarts with each feedback cycle or power-down
		if (pd_now || fb_wrap) begin
			next_state.a_left = state.n_latch.swallow_count;
		end else if (pre_wrap && state.a_left != '0) begin
			next_state.a_left = state.a_left - A_W'(1);
		end

		// Phase/frequency detector flags; a new edge wins over the clear
		if (pd_now) begin
			next_state.ref_flag = 1'b0;
			next_state.fb_flag = 1'b0;
			next_state.abl_cnt = '0;
		end else begin
			if (state.ref_flag && state.fb_flag) begin
				// Both pumps on: hold the minimum width, then clear
				if (state.abl_cnt == ABL_LAST) begin
					next_state.ref_flag = 1'b0;
					next_state.fb_flag = 1'b0;
					next_state.abl_cnt = '0;
				end else begin
					next_state.abl_cnt = state.abl_cnt + ABL_W'(1);
				end
			end
			if (ref_wrap) begin
				next_state.ref_flag = 1'b1;
			end
			if (fb_wrap) begin
				next_state.fb_flag = 1'b1;
			end
		end

		// Pump commands after polarity; negative swaps the pair
		if (state.r_latch.polarity) begin
			next_state.pump.up = state.ref_flag;
			next_state.pump.down = state.fb_flag;
		end else begin
			next_state.pump.up = state.fb_flag;
			next_state.pump.down = state.ref_flag;
		end

		// Pump pin: float when off, balanced or powered down
		if (pd_now) begin
			next_state.pump = '0;
		end else if (state.r_latch.test) begin
			next_state.pump.oe = 1'b1;
			next_state.pump.level = state.r_latch.polarity ? fb_wrap : ref_wrap;
			next_state.pump.up = 1'b0;
			next_state.pump.down = 1'b0;
		end else if (state.r_latch.pump_output_float) begin
			next_state.pump = '0;
		end else begin
			// Both on at once is a net zero current, so the pin floats
			next_state.pump.oe = next_state.pump.up ^ next_state.pump.down;
			next_state.pump.level = next_state.pump.up;
		end
		if (state.r_latch.pump_output_float && !state.r_latch.test) begin
			next_state.pump.up = 1'b0;
			next_state.pump.down = 1'b0;
		end

		// Divider pulses and power indications
		next_state.ref_div = ref_wrap;
		next_state.fb_div = fb_wrap;
		next_state.powered_down = pd_now;
		next_state.rf_float = pd_now;
		next_state.osc_float = pd_now;
	end

	// Single state register; latches reset to a powered-down, floating pump
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= '{shift: '0, ser_clk_q: 1'b0, strobe_q: 1'b0, osc_q: 1'b0, rf_q: 1'b0,
				r_latch: R_LATCH_RST, n_latch: N_LATCH_RST, a_left: '0, ref_flag: 1'b0,
				fb_flag: 1'b0, abl_cnt: '0, pump: '0, ref_div: 1'b0, fb_div: 1'b0,
				powered_down: 1'b1, rf_float: 1'b1, osc_float: 1'b1};
		end else begin
			state <= next_state;
		end
	end

	// Outputs straight from the state register
	assign pump_output_out = state.pump.level;
	assign pump_output_oe_out = state.pump.oe;
	assign pump_up_out = state.pump.up;
	assign pump_down_out = state.pump.down;
	assign ref_div_out = state.ref_div;
	assign fb_div_out = state.fb_div;
	assign powered_down_out = state.powered_down;
	assign rf_input_float_out = state.rf_float;
	assign osc_input_float_out = state.osc_float;

	// Checks on the core's own behaviour
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	property p_shift_in;
		(ser_clk_in && !state.ser_clk_q) |=>
			state.shift == {$past(state.shift[SR_W-2:0]), $past(ser_data_in)};
	endproperty
	a_shift_in: assert property (p_shift_in)
		else $error("serial bit not shifted in on rising serial clock");

	property p_load_ref;
		(latch_load_strobe_in && !state.strobe_q && state.shift[ADDR_BIT] == SEL_REF) |=>
			state.r_latch == $past(state.shift[R_LATCH_MSB:R_LATCH_LSB]);
	endproperty
	a_load_ref: assert property (p_load_ref)
		else $error("reference latch not loaded on strobe with select high");

	property p_load_fb;
		(latch_load_strobe_in && !state.strobe_q && state.shift[ADDR_BIT] != SEL_REF) |=>
			state.n_latch == $past(state.shift[N_LATCH_MSB:N_LATCH_LSB]) &&
			$stable(state.r_latch);
	endproperty
	a_load_fb: assert property (p_load_fb)
		else $error("feedback latch not loaded on strobe with select low");

	property p_ce_float;
		!chip_enable_in |=> !pump_output_oe_out && powered_down_out && !pump_up_out;
	endproperty
	a_ce_float: assert property (p_ce_float)
		else $error("pump not floated after chip enable low");

	property p_bit_float;
		(chip_enable_in && state.n_latch.power_down_bit) |=>
			rf_input_float_out && osc_input_float_out ##1 !ref_div_out && !fb_div_out;
	endproperty
	a_bit_float: assert property (p_bit_float)
		else $error("power-down bit did not float inputs or stop dividers");

	property p_pd_quiet;
		powered_down_out |-> !pump_output_oe_out && !pump_up_out && !pump_down_out;
	endproperty
	a_pd_quiet: assert property (p_pd_quiet)
		else $error("pump active during power-down");

	property p_swallow_reset;
		pd_now |=> state.a_left == $past(state.n_latch.swallow_count) && !state.ref_flag;
	endproperty
	a_swallow_reset: assert property (p_swallow_reset)
		else $error("counters not returned to start in power-down");

	property p_swallow_step;
		(!pd_now && pre_wrap && !fb_wrap && state.a_left != '0) |=>
			state.a_left == $past(state.a_left) - A_W'(1);
	endproperty
	a_swallow_step: assert property (p_swallow_step)
		else $error("swallow counter did not step on prescaler pulse");

	property p_min_pulse;
		(!pd_now && state.ref_flag && state.fb_flag && state.abl_cnt == '0) |->
			(state.ref_flag && state.fb_flag) [*2];
	endproperty
	a_min_pulse: assert property (p_min_pulse)
		else $error("detector pulses shorter than the dead-zone minimum");

	property p_polarity;
		(!pd_now && !state.r_latch.test && !state.r_latch.pump_output_float &&
			state.r_latch.polarity && state.ref_flag && !state.fb_flag) |=>
			pump_up_out && !pump_down_out && pump_output_out && pump_output_oe_out;
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("positive polarity did not pump up on reference lead");

	property p_test_route;
		(!pd_now && state.r_latch.test) |=> pump_output_oe_out &&
			pump_output_out == ($past(state.r_latch.polarity) ? $past(fb_wrap) : $past(ref_wrap));
	endproperty
	a_test_route: assert property (p_test_route)
		else $error("test mode did not route the selected divider to the pump");

	// Pin drive, detector flags, divider clearing and shift hold
	property p_pin_drive;
		(!pd_now && !state.r_latch.test && !state.r_latch.pump_output_float) |=>
			pump_output_oe_out == (pump_up_out ^ pump_down_out) &&
			(!pump_output_oe_out || pump_output_out == pump_up_out);
	endproperty
	a_pin_drive: assert property (p_pin_drive)
		else $error("pump pin drive does not follow the commands");

	property p_polarity_neg;
		(!pd_now && !state.r_latch.test && !state.r_latch.pump_output_float &&
			!state.r_latch.polarity && state.ref_flag && !state.fb_flag) |=>
			pump_down_out && !pump_up_out && !pump_output_out && pump_output_oe_out;
	endproperty
	a_polarity_neg: assert property (p_polarity_neg)
		else $error("negative polarity did not pump down on reference lead");

	property p_float_bit;
		(!pd_now && state.r_latch.pump_output_float && !state.r_latch.test) |=>
			!pump_output_oe_out && !pump_up_out && !pump_down_out;
	endproperty
	a_float_bit: assert property (p_float_bit)
		else $error("pump not floated by the float bit");

	property p_ref_flag;
		(!pd_now && ref_wrap) |=> state.ref_flag && ref_div_out;
	endproperty
	a_ref_flag: assert property (p_ref_flag)
		else $error("reference pulse did not reach the detector");

	property p_fb_flag;
		(!pd_now && fb_wrap) |=> state.fb_flag && fb_div_out;
	endproperty
	a_fb_flag: assert property (p_fb_flag)
		else $error("feedback pulse did not reach the detector");

	property p_pd_clear;
		pd_now |=> !ref_wrap && !pre_wrap && !fb_wrap && !state.fb_flag;
	endproperty
	a_pd_clear: assert property (p_pd_clear)
		else $error("dividers not held at their start in power-down");

	property p_min_clear;
		(!pd_now && state.ref_flag && state.fb_flag && state.abl_cnt == ABL_LAST &&
			!ref_wrap && !fb_wrap) |=> !state.ref_flag && !state.fb_flag;
	endproperty
	a_min_clear: assert property (p_min_clear)
		else $error("detector flags not cleared after the minimum pulse");

	property p_shift_hold;
		!(ser_clk_in && !state.ser_clk_q) |=> $stable(state.shift);
	endproperty
	a_shift_hold: assert property (p_shift_hold)
		else $error("shift register changed without a serial clock edge");

	// Main scenarios worth seeing
	c_load_in_pd: cover property (powered_down_out && latch_load_strobe_in && !state.strobe_q);
	c_lock_pulse: cover property (state.ref_flag && state.fb_flag && !pd_now);
	c_wake: cover property (powered_down_out ##1 !powered_down_out ##[1:200] ref_div_out);
	c_pump_down: cover property (pump_down_out && pump_output_oe_out && !pump_output_out);
	c_test_mode: cover property (state.r_latch.test && pump_output_out);
endmodule : psd_core
`default_nettype wire

// File: bench/psd_host.sv
// Host model that drives the three-wire serial programming port
`timescale 1ns/1ps
`default_nettype none
module psd_host
	import psd_pkg::*;
(
	// Clock
	input wire logic clk_in,
	// Serial port
	output logic ser_clk_out,
	output logic ser_data_out,
	output logic latch_load_strobe_out
);
	// Idle port: clock parked low, no strobe
	initial begin
		ser_clk_out = 1'b0;
		ser_data_out = 1'b0;
		latch_load_strobe_out = 1'b0;
	end

	// One word, clock low two cycles and high three (two for the last bit), then one strobe
	task automatic send(input logic [SR_W-1:0] w);
		for (int i = SR_W - 1; i >= 0; i--) begin
			@(negedge clk_in);
			ser_clk_out = 1'b0;
			ser_data_out = w[i];
			repeat (2) @(negedge clk_in);
			ser_clk_out = 1'b1;
			repeat (2) @(negedge clk_in);
		end
		// Data is stale now, so show its inverse rather than the last bit
		ser_clk_out = 1'b0;
		ser_data_out = ~w[0];
		@(negedge clk_in);
		latch_load_strobe_out = 1'b1;
		repeat (2) @(negedge clk_in);
		latch_load_strobe_out = 1'b0;
	endtask : send
endmodule : psd_host
`default_nettype wire

// File: bench/tb_psd_core.sv
// Self-checking bench of the synthesizer digital core
`timescale 1ns/1ps
`default_nettype none
module tb_psd_core
	import psd_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic osc = 1'b0;
	logic rf = 1'b0;
	logic ce = 1'b1;
	logic [1:0] osc_cnt = 2'h0;
	logic ser_clk, ser_data, strobe;
	logic pump_output, pump_oe, pump_up, pump_down;
	logic ref_div, fb_div, pwr_dn, rf_float, osc_float;
	int fails = 0;
	int num_checks = 0;

	psd_core dut (
		.ref_clk_in(clk), .rst_n_in(rst_n),
		.reference_osc_input_in(osc), .rf_input_in(rf), .chip_enable_in(ce),
		.ser_clk_in(ser_clk), .ser_data_in(ser_data), .latch_load_strobe_in(strobe),
		.pump_output_out(pump_output), .pump_output_oe_out(pump_oe),
		.pump_up_out(pump_up), .pump_down_out(pump_down),
		.ref_div_out(ref_div), .fb_div_out(fb_div), .powered_down_out(pwr_dn),
		.rf_input_float_out(rf_float), .osc_input_float_out(osc_float)
	);
	psd_host host (.clk_in(clk), .ser_clk_out(ser_clk), .ser_data_out(ser_data),
		.latch_load_strobe_out(strobe));

	// 250 MHz system clock
	always #2 clk = ~clk;

	// Reference at 31.25 MHz (under its 40 MHz ceiling), RF at 125 MHz
	always @(negedge clk) begin
		osc_cnt <= osc_cnt + 2'h1;
		if (osc_cnt == 2'h3) osc <= ~osc;
		rf <= ~rf;
	end

	task automatic chk(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			fails++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic results();
		$display("Checks %0d, errors %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results

	function automatic logic [SR_W-1:0] r_word(input logic tst, input logic pol,
		input logic flt, input logic [R_W-1:0] ratio);
		psd_r_latch_type r;
		r = '{test: tst, reserved: 1'b0, polarity: pol, pump_output_float: flt, ratio: ratio};
		return {3'h0, r, SEL_REF};
	endfunction : r_word

	function automatic logic [SR_W-1:0] n_word(input logic [B_W-1:0] m,
		input logic [A_W-1:0] s, input logic pd);
		psd_n_latch_type n;
		n = '{main_count: m, swallow_count: s, power_down_bit: pd, ctl_spare: 1'b0};
		return {n, ~SEL_REF};
	endfunction : n_word

	function automatic logic pulse(input logic fb);
		return fb ? fb_div : ref_div;
	endfunction : pulse

	// Cycles from one divider pulse to the next; test mode pin must mirror it
	task automatic spacing(input logic fb, output int n);
		int k;
		k = 0;
		n = 0;
		while (pulse(fb) !== 1'b1 && k < 20000) begin
			@(negedge clk);
			k++;
		end
		do begin
			@(negedge clk);
			n++;
			chk(pump_output === pulse(fb) && pump_oe === 1'b1, "test pin");
		end while (pulse(fb) !== 1'b1 && n < 20000);
	endtask : spacing

	// Reference ratios at both ends of the range; first span may straddle a reload
	task automatic ref_case();
		int ratios[3] = '{2, 7, 1023};
		int n;
		foreach (ratios[i]) begin
			host.send(r_word(1'b1, 1'b0, 1'b1, R_W'(ratios[i])));
			spacing(1'b0, n);
			spacing(1'b0, n);
			chk(n == ratios[i] * 8, "reference ratio");
		end
	endtask : ref_case

	// Feedback ratio 32*main+swallow, from the 992 floor upward
	task automatic fb_case();
		int mains[3] = '{31, 32, 40};
		int swal[3] = '{0, 5, 31};
		int n;
		host.send(r_word(1'b1, 1'b1, 1'b1, 10'h004));
		foreach (mains[i]) begin
			host.send(n_word(B_W'(mains[i]), A_W'(swal[i]), 1'b0));
			spacing(1'b1, n);
			spacing(1'b1, n);
			chk(n == (32 * mains[i] + swal[i]) * 2, "feedback ratio");
		end
	endtask : fb_case

	// Reference leads by far, so one steady direction, with a 2-cycle overlap per compare
	task automatic pump_case(input logic pol, input logic flt);
		int up_n, dn_n, run;
		up_n = 0;
		dn_n = 0;
		run = 0;
		host.send(r_word(1'b0, pol, flt, 10'h004));
		repeat (100) @(negedge clk);
		repeat (2500) begin
			@(negedge clk);
			if (pump_oe === 1'b1) begin
				chk(pump_output === pump_up && pump_up !== pump_down, "pin drive");
				if (pump_output === 1'b1) up_n++;
				else dn_n++;
			end
			if (pump_up === 1'b1 && pump_down === 1'b1) run++;
			else if (run != 0 && !flt) begin
				chk(run == PFD_MIN_PULSE_CYC, "overlap width");
				run = 0;
			end
		end
		if (flt) chk(up_n == 0 && dn_n == 0, "floating pump");
		else chk(pol ? (up_n > 0 && dn_n == 0) : (dn_n > 0 && up_n == 0), "polarity");
	endtask : pump_case

	// Chip enable off, reload while down, then both dividers restart together
	task automatic ce_case();
		int t_ref, t_fb;
		host.send(n_word(10'h020, 5'h00, 1'b0));
		ce = 1'b0;
		repeat (3) @(negedge clk);
		chk(pwr_dn === 1'b1 && pump_oe === 1'b0, "chip enable low");
		host.send(r_word(1'b0, 1'b1, 1'b0, 10'h100));
		chk(ref_div === 1'b0 && fb_div === 1'b0, "dividers halted");
		ce = 1'b1;
		t_ref = 0;
		t_fb = 0;
		for (int k = 1; k < 3000 && (t_ref == 0 || t_fb == 0); k++) begin
			@(negedge clk);
			if (t_ref == 0 && ref_div === 1'b1) t_ref = k;
			if (t_fb == 0 && fb_div === 1'b1) t_fb = k;
		end
		chk(t_ref > 2035 && t_ref < 2070, "reference restart");
		chk(t_fb - t_ref < 70 && t_ref - t_fb < 70, "feedback alignment");
	endtask : ce_case

	// Programmed power-down while both dividers run, then woken by the serial port
	task automatic pd_bit_case();
		int seen;
		seen = 0;
		host.send(n_word(10'h020, 5'h00, 1'b1));
		chk(pwr_dn === 1'b1 && rf_float === 1'b1 && osc_float === 1'b1, "bit power-down");
		repeat (2100) begin
			@(negedge clk);
			if (ref_div !== 1'b0 || fb_div !== 1'b0 || pump_oe !== 1'b0) seen++;
		end
		chk(seen == 0, "dividers stopped by bit");
		host.send(n_word(10'h020, 5'h00, 1'b0));
		chk(pwr_dn === 1'b0 && rf_float === 1'b0 && osc_float === 1'b0, "bit wake");
	endtask : pd_bit_case

	// Hang guard, well past the expected run of about 57000 cycles
	initial begin
		repeat (90000) @(posedge clk);
		fails++;
		$display("Error at %0t: watchdog expired", $time);
		results();
	end

	// Main sequence
	initial begin
		repeat (4) @(negedge clk);
		chk(pwr_dn === 1'b1 && pump_oe === 1'b0 && rf_float === 1'b1, "reset state");
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		chk(pwr_dn === 1'b1 && osc_float === 1'b1, "reset power-down");
		host.send(n_word(10'h020, 5'h00, 1'b0));
		repeat (3) @(negedge clk);
		chk(pwr_dn === 1'b0 && rf_float === 1'b0 && osc_float === 1'b0, "power up");
		ref_case();
		fb_case();
		host.send(n_word(10'h01f, 5'h00, 1'b0));
		pump_case(1'b1, 1'b0);
		pump_case(1'b0, 1'b0);
		pump_case(1'b1, 1'b1);
		pd_bit_case();
		ce_case();
		results();
	end
endmodule : tb_psd_core
`default_nettype wire
